// ---- shared/cwd_pkg.sv ----
// Functional notes
// - Enabled at reset, two-second timeout, resets system
// - Clearing enable stops supervision unless locked
// - Counter advances on rising crystal clock edges only
// - Control writes only through two-step unlock
// - Flash lock forces response 0, enable 1
// - Timeout field still writable while locked
// - Sixteen-bit counter; field picks expiry bit
// - Codes 0-7 double from 15.6 ms; reset 7
// - Code 1000 resets the system at once
// - Code 1001 triggers serial-download reset at once
// - Expiry resets when response 0, else interrupts
// - Every timeout sets the status bit
// - Status cleared only by write 0 or pin
// - Setting enable clears the counter each time
// - Guard interrupt high priority, not globally maskable
// - Guard interrupt vectors to 0x005b
package cwd_pkg;

  // Register map
  localparam logic [7:0] CTRL_ADDR = 8'hc0;
  localparam int PRE_LSB = 4;
  localparam int RESP_BIT = 3;
  localparam int STAT_BIT = 2;
  localparam int EN_BIT = 1;
  localparam int UNLOCK_BIT = 0;

  // Reset values
  localparam logic [3:0] PRE_RST = 4'h7;
  localparam logic RESP_RST = 1'b0;
  localparam logic STAT_RST = 1'b0;
  localparam logic EN_RST = 1'b1;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Timeout codes
  localparam logic [3:0] PRE_MAX_TIMED = 4'h7;
  localparam logic [3:0] PRE_NOW_RESET = 4'h8;
  localparam logic [3:0] PRE_NOW_DOWNLOAD = 4'h9;

  // Timing: code 0 is 15.6 ms of crystal ticks, each code doubles it
  localparam int XTAL_HZ = 32768;
  localparam int BASE_TIMEOUT_US = 15600;
  localparam int BASE_SHIFT = 9;
  localparam int CNT_W = 16;

  // Interrupt vector
  localparam logic [15:0] GUARD_VECTOR_ADDR = 16'h005b;

  // Unlock sequencer, Gray coded
  typedef enum logic [1:0] {
    CWD_IDLE = 2'b00,
    CWD_ARMED = 2'b01,
    CWD_OPEN = 2'b11
  } cwd_arm_t;

  typedef struct packed {
    cwd_arm_t arm;
    logic [3:0] pre;
    logic resp;
    logic stat;
    logic en;
    logic [CNT_W-1:0] cnt;
    logic rst;
    logic dl;
    logic irq;
    logic [7:0] rdata;
    logic [15:0] vec;
  } cwd_state_t;

  typedef struct packed {
    logic prev;
    logic tick;
  } cwd_tick_t;

endpackage

// ---- core/cwd_xtal_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_xtal_tick (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Crystal clock level
  input wire logic xtal,
  // One-cycle pulse per rising crystal edge
  output logic tick
);
  cwd_pkg::cwd_tick_t s_q;
  cwd_pkg::cwd_tick_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = xtal;
    s_d.tick = xtal & ~s_q.prev;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule // cwd_xtal_tick
`default_nettype wire

// ---- core/cwd_expiry.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_expiry (
  // Counter and settings
  input wire logic [15:0] cnt,
  input wire logic [3:0] pre,
  input wire logic en,
  input wire logic tick,
  // Expiry on this tick
  output logic expire
);
  // Low bits that must all be ones just before the selected bit rolls over
  function automatic logic [15:0] term_mask(input logic [3:0] code);
    logic [16:0] m;
    m = (17'h00001 << (5'(cwd_pkg::BASE_SHIFT) + {1'b0, code})) - 17'h00001;
    return m[15:0];
  endfunction

  logic [15:0] mask;

  always_comb begin
    mask = term_mask(pre);
    expire = 1'b0;
    if (en && tick && pre <= cwd_pkg::PRE_MAX_TIMED) begin
      expire = ((cnt & mask) == mask);
    end
  end
endmodule // cwd_expiry
`default_nettype wire

// ---- core/cwd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_top (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Crystal clock, 32.768 kHz level
  input wire logic XTAL_CLK,
  // Special function register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Instruction boundary from the core
  input wire logic INSTR_END,
  // Flash lock bit, low locks the settings
  input wire logic GUARD_LOCK_N,
  // Reset requests
  output logic SYS_RESET_REQ,
  output logic DOWNLOAD_RESET_REQ,
  // Guard interrupt
  output logic GUARD_IRQ,
  output logic [15:0] GUARD_VECTOR,
  input wire logic GUARD_IRQ_ACK
);
  cwd_pkg::cwd_state_t s_q;
  cwd_pkg::cwd_state_t s_d;
  logic tick;
  logic expire;
  logic wr_hit;
  logic rd_hit;
  logic locked;
  logic [3:0] new_pre;

  cwd_xtal_tick u_tick (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .xtal(XTAL_CLK),
    .tick(tick)
  );

  cwd_expiry u_expiry (
    .cnt(s_q.cnt),
    .pre(s_q.pre),
    .en(s_q.en),
    .tick(tick),
    .expire(expire)
  );

  always_comb begin
    s_d = s_q;
    s_d.rst = 1'b0;
    s_d.dl = 1'b0;
    wr_hit = SFR_WR && (SFR_ADDR == cwd_pkg::CTRL_ADDR);
    rd_hit = SFR_RD && (SFR_ADDR == cwd_pkg::CTRL_ADDR);
    locked = ~GUARD_LOCK_N;
    new_pre = SFR_WDATA[cwd_pkg::PRE_LSB +: 4];

    if (s_q.rst || s_q.dl) begin
      // Internal reinit after own reset request; status survives
      s_d.arm = cwd_pkg::CWD_IDLE;
      s_d.pre = cwd_pkg::PRE_RST;
      s_d.resp = cwd_pkg::RESP_RST;
      s_d.en = cwd_pkg::EN_RST;
      s_d.cnt = cwd_pkg::CNT_RST;
      s_d.irq = 1'b0;
    end else begin
      // Count crystal ticks while enabled
      if (s_q.en && tick) begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end

      // Unlock sequencer
      case (s_q.arm)
        cwd_pkg::CWD_IDLE: begin
          if (wr_hit && SFR_WDATA[cwd_pkg::UNLOCK_BIT]) begin
            s_d.arm = cwd_pkg::CWD_ARMED;
          end
        end
        cwd_pkg::CWD_ARMED: begin
          if (INSTR_END) begin
            s_d.arm = cwd_pkg::CWD_OPEN;
          end
        end
        cwd_pkg::CWD_OPEN: begin
          if (wr_hit) begin
            s_d.arm = cwd_pkg::CWD_IDLE;
            if (new_pre <= cwd_pkg::PRE_MAX_TIMED) begin
              s_d.pre = new_pre;
            end
            if (new_pre == cwd_pkg::PRE_NOW_RESET) begin
              s_d.rst = 1'b1;
            end
            if (new_pre == cwd_pkg::PRE_NOW_DOWNLOAD) begin
              s_d.dl = 1'b1;
            end
            s_d.resp = SFR_WDATA[cwd_pkg::RESP_BIT];
            s_d.en = SFR_WDATA[cwd_pkg::EN_BIT];
            if (SFR_WDATA[cwd_pkg::EN_BIT] || locked) begin
              s_d.cnt = cwd_pkg::CNT_RST;
            end
            if (!SFR_WDATA[cwd_pkg::STAT_BIT]) begin
              s_d.stat = 1'b0;
            end
          end else if (INSTR_END) begin
            s_d.arm = cwd_pkg::CWD_IDLE;
          end
        end
        default: begin
          s_d.arm = cwd_pkg::CWD_IDLE;
        end
      endcase

      // Vector taken clears the pending request
      if (GUARD_IRQ_ACK) begin
        s_d.irq = 1'b0;
      end

      // Expiry: set wins over any clear in the same cycle
      if (expire) begin
        s_d.stat = 1'b1;
        if (s_q.resp) begin
          s_d.irq = 1'b1;
          s_d.cnt = cwd_pkg::CNT_RST;
        end else begin
          s_d.rst = 1'b1;
        end
      end
    end

    // Flash lock pins the enable and response settings
    if (locked) begin
      s_d.resp = 1'b0;
      s_d.en = 1'b1;
    end

    if (rd_hit) begin
      s_d.rdata = {s_q.pre, s_q.resp, s_q.stat, s_q.en, (s_q.arm != cwd_pkg::CWD_IDLE)};
    end else begin
      s_d.rdata = cwd_pkg::RDATA_RST;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_q.arm <= cwd_pkg::CWD_IDLE;
      s_q.pre <= cwd_pkg::PRE_RST;
      s_q.resp <= cwd_pkg::RESP_RST;
      s_q.stat <= cwd_pkg::STAT_RST;
      s_q.en <= cwd_pkg::EN_RST;
      s_q.cnt <= cwd_pkg::CNT_RST;
      s_q.rst <= 1'b0;
      s_q.dl <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.rdata <= cwd_pkg::RDATA_RST;
      s_q.vec <= cwd_pkg::GUARD_VECTOR_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops; the interrupt is not gated by any global enable
  assign SFR_RDATA = s_q.rdata;
  assign SYS_RESET_REQ = s_q.rst;
  assign DOWNLOAD_RESET_REQ = s_q.dl;
  assign GUARD_IRQ = s_q.irq;
  assign GUARD_VECTOR = s_q.vec;
endmodule // cwd_top
`default_nettype wire

// ---- tb/cwd_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_top_sva (
  // Watched ports
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic GUARD_LOCK_N,
  input wire logic SYS_RESET_REQ,
  input wire logic DOWNLOAD_RESET_REQ,
  input wire logic GUARD_IRQ,
  input wire logic [15:0] GUARD_VECTOR,
  input wire logic GUARD_IRQ_ACK
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_vec_fixed: assert property (GUARD_VECTOR == 16'h005b)
    else $error("vector");
  a_unmapped_zero: assert property (SFR_RD && SFR_ADDR != 8'hc0 |=> SFR_RDATA == 8'h00)
    else $error("unmapped read");
  a_rst_pulse: assert property (SYS_RESET_REQ |=> !SYS_RESET_REQ [*2])
    else $error("reset pulse");
  a_dl_pulse: assert property (DOWNLOAD_RESET_REQ |=> !DOWNLOAD_RESET_REQ [*2])
    else $error("download pulse");
  a_lock_fields: assert property ($past(SFR_RD) && $past(SFR_ADDR) == 8'hc0
    && !$past(GUARD_LOCK_N, 3) && !$past(GUARD_LOCK_N, 2)
    |-> SFR_RDATA[3] == 1'b0 && SFR_RDATA[1] == 1'b1) else $error("lock fields");
  a_lock_no_irq: assert property (!$past(GUARD_LOCK_N, 2) && !$past(GUARD_LOCK_N)
    |-> !$rose(GUARD_IRQ)) else $error("irq while locked");
  a_irq_ack: assert property (GUARD_IRQ && GUARD_IRQ_ACK |=> !GUARD_IRQ)
    else $error("ack");
  a_irq_hold: assert property (GUARD_IRQ && !GUARD_IRQ_ACK && !SYS_RESET_REQ
    && !DOWNLOAD_RESET_REQ |=> GUARD_IRQ) else $error("irq dropped");
endmodule // cwd_top_sva
bind cwd_top cwd_top_sva i_sva (.SYS_CLK, .RST_N, .SFR_ADDR, .SFR_RD, .SFR_RDATA,
  .GUARD_LOCK_N, .SYS_RESET_REQ, .DOWNLOAD_RESET_REQ, .GUARD_IRQ, .GUARD_VECTOR,
  .GUARD_IRQ_ACK);
`default_nettype wire

// ---- tb/cwd_fw_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_fw_model #(
  parameter int ACK_DLY = 5
) (
  // Clock, reset, crystal
  input wire logic clk,
  input wire logic rst_n,
  output logic xtal,
  // Interrupt side
  input wire logic irq,
  output logic ack
);
  int n = 0;
  logic xt_q = 1'b0;
  logic ack_q = 1'b0;
  always @(negedge clk) begin
    xt_q <= ~xt_q;
    ack_q <= irq && n == ACK_DLY;
    n <= (irq && !ack_q && rst_n) ? n + 1 : 0;
  end
  assign xtal = xt_q;
  assign ack = ack_q;
endmodule // cwd_fw_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ie = 1'b0;
  logic lk_n = 1'b1;
  logic [7:0] a = 8'h00;
  logic [7:0] d = 8'h00;
  wire [7:0] q;
  wire [2:0] ev;
  wire [15:0] vec;
  wire xt;
  wire ack;
  int errors = 0;
  int n_compared = 0;
  int c;
  int b;
  int n_rst = 0;
  int n_dl = 0;
  always #25 clk = ~clk;
  // Count reset pulses, which may pass while a write task is still running
  always @(negedge clk) begin
    n_rst <= n_rst + int'(ev[0] === 1'b1);
    n_dl <= n_dl + int'(ev[1] === 1'b1);
  end
  cwd_top i_cwd_top (.SYS_CLK(clk), .RST_N(rst_n), .XTAL_CLK(xt), .SFR_ADDR(a),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(d), .SFR_RDATA(q), .INSTR_END(ie),
    .GUARD_LOCK_N(lk_n), .SYS_RESET_REQ(ev[0]), .DOWNLOAD_RESET_REQ(ev[1]),
    .GUARD_IRQ(ev[2]), .GUARD_VECTOR(vec), .GUARD_IRQ_ACK(ack));
  cwd_fw_model i_cwd_fw_model (.clk(clk), .rst_n(rst_n), .xtal(xt), .irq(ev[2]), .ack(ack));
  task automatic print_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic put(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk);
    {wr, a, d} = {1'b1, ad, dt};
    @(negedge clk);
    {wr, ie} = 2'b01;
    @(negedge clk);
    ie = 1'b0;
  endtask
  task automatic ulk(input logic [7:0] dt);
    put(8'hc0, 8'h01);
    put(8'hc0, dt);
  endtask
  task automatic get(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clk);
    {rd, a} = {1'b1, ad};
    @(negedge clk);
    rd = 1'b0;
    chk("rdata", {8'h00, q}, {8'h00, exp});
  endtask
  task automatic wt(input int k, input int lim);
    c = 0;
    while (ev[k] !== 1'b1) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        errors++;
        print_verdict();
      end
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    get(8'hc0, 8'h72);
    chk("vector", vec, 16'h005b);
    put(8'hc0, 8'h00);
    get(8'hc0, 8'h72);
    get(8'h00, 8'h00);
    ulk(8'h02);
    wt(0, 1100);
    chk("period", 16'(c > 1000 && c < 1040), 16'h0001);
    get(8'hc0, 8'h76);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    get(8'hc0, 8'h72);
    ulk(8'h0a);
    wt(2, 1100);
    repeat (20) @(negedge clk);
    wt(2, 1100);
    chk("period", 16'(c > 950 && c < 1040), 16'h0001);
    get(8'hc0, 8'h0e);
    ulk(8'h00);
    repeat (1500) @(negedge clk);
    get(8'hc0, 8'h00);
    lk_n = 1'b0;
    get(8'hc0, 8'h02);
    ulk(8'h38);
    get(8'hc0, 8'h32);
    lk_n = 1'b1;
    b = n_rst;
    ulk(8'h82);
    repeat (2) @(negedge clk);
    chk("now_reset", 16'(n_rst - b), 16'h0001);
    get(8'hc0, 8'h72);
    b = n_dl;
    ulk(8'h92);
    repeat (2) @(negedge clk);
    chk("download_reset", 16'(n_dl - b), 16'h0001);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
